// *** shared/tses_pkg.sv ***
// constants and types for the transfer switch event/status block
// assumes a 20 MHz system clock and codes held as 4-digit bcd
package tses_pkg;
  // clock and time base
  localparam int CLK_HZ = 20_000_000;
  localparam int QTR_MS = 250;
  localparam int QTR_CYCLES_DEF = CLK_HZ / 1000 * QTR_MS;
  localparam int QTR_PER_SEC = 4;
  // flash-out timing in quarter seconds
  localparam logic [3:0] PULSE_Q = 4'h1;
  localparam logic [3:0] DGAP_Q = 4'h4;
  localparam logic [3:0] RGAP_Q = 4'hC;
  // speed raise step carried by the message, in mHz
  localparam int SPEED_STEP_MHZ = 500;
  localparam int HIST_DEPTH_DEF = 50;
  // wishbone byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TIMER = 8'h04;
  localparam logic [7:0] REG_EVENTS = 8'h08;
  localparam logic [7:0] REG_SEQ = 8'h0C;
  localparam logic [7:0] REG_FAULT = 8'h10;
  localparam logic [7:0] REG_HIDX = 8'h14;
  localparam logic [7:0] REG_HDATA = 8'h18;
  // control register bits
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam int C_UTG = 0;
  localparam int C_G2G = 1;
  localparam int C_ASYNC = 2;
  localparam int C_TEST = 3;
  localparam int C_TEST_S2 = 4;
  localparam int C_SYNC = 5;
  localparam int C_SPEED = 6;
  // delay timers, slot order matches their event bits
  localparam int TMR_N = 6;
  localparam int T_START_A = 0;
  localparam int T_COOL = 3;
  localparam logic [TMR_N-1:0][15:0] TMR_CODE = {16'h0116, 16'h0115,
    16'h0114, 16'h0113, 16'h0112, 16'h0109};
  // event vector bits
  localparam int EV_W = 17;
  localparam int E_S1CON = 0;
  localparam int E_S1AV = 1;
  localparam int E_S2CON = 2;
  localparam int E_S2AV = 3;
  localparam int E_TSA = 4;
  localparam int E_TSB = 5;
  localparam int E_TMR0 = 6;
  localparam int E_TRANSFER_PENDING_DELAY = 11;
  localparam int E_TEST = 12;
  localparam int E_SYNC = 13;
  localparam int E_INH = 14;
  localparam int E_SVC = 15;
  localparam int E_SPEED = 16;
  // display codes
  localparam logic [15:0] CODE_S1CON = 16'h0101;
  localparam logic [15:0] CODE_S2CON = 16'h0103;
  localparam logic [15:0] CODE_SYNC = 16'h0119;
  localparam logic [15:0] CODE_SPEED = 16'h0144;
  // acknowledge-required faults; index FLT_N in history queue is speed
  localparam int FLT_N = 4;
  localparam logic [FLT_N-1:0][15:0] FAULT_CODE = {16'h1121, 16'h1114,
    16'h1113, 16'h0441};
  // flash-out events, lowest code first
  localparam int FLASH_N = 2;
  localparam logic [FLASH_N-1:0][1:0] FLASH_BIT = {2'h3, 2'h0};
  localparam logic [FLASH_N-1:0][1:0] FLASH_TOP = {2'h3, 2'h2};
  // synchronised pin vector layout
  localparam int PIN_W = 20;
  localparam int P_S1 = 0;
  localparam int P_S2 = 5;
  localparam int P_S1POS = 10;
  localparam int P_S2POS = 11;
  localparam int P_SVC = 12;
  localparam int P_INH = 13;
  localparam int P_RST = 14;
  localparam int P_DONE = 15;
  localparam int P_FLT = 16;
  localparam int CHK_W = 5;
  typedef enum logic [2:0] {F_IDLE, F_ON, F_OFF, F_PAUSE, F_REST}
    tses_flash_type;
endpackage

// *** rtl/tses_core.sv ***
// event and status logic of the transfer switch controller
// assumes pins are asynchronous, seq_out_i is on clk_i, wishbone classic
// How it works
// - each of eight sequencer outputs raises its own event on change.
// - sequencer events only in utility-to-genset mode.
// - service tool event follows the tool-present pin.
// - source one available when all five checks pass; led and relay.
// - source two available when all its checks pass; led and relay.
// - connected events follow position pins; led, relay, display.
// - speed request logged, raises 1/2 Hz, ends at transfer done.
// - sync event while pending; displayed only with active sync.
// - cool-down event only while that timer runs.
// - transfer pending event follows pretransfer output and timer.
// - retransfer delay event only while that timer runs.
// - start-A delay event while timer runs; start A after it.
// - forward transfer delay event only while that timer runs.
// - neutral hold event only while that timer runs.
// - display shows active delay code and remaining whole seconds.
// - test in progress lights test led and relay.
// - test start A also drives emergency start A.
// - test start B with start B only genset-to-genset, source two.
// - transfer inhibit event follows the inhibit pin.
// - acknowledge-required faults latch until panel reset.
// - flagged faults flash as numeric codes on status led.
// - digits flash with short gaps, longer gap before repeating.
// - heartbeat blinks at 1/2 Hz while nothing flashes.
// - acknowledged events go to a 50 entry history store.
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
module tses_core #(
  parameter int QTR_CYCLES = tses_pkg::QTR_CYCLES_DEF,
  parameter int HIST_DEPTH = tses_pkg::HIST_DEPTH_DEF
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // sensing and panel pins, asynchronous
  input wire logic [tses_pkg::CHK_W-1:0] s1_checks_ok_i,
  input wire logic [tses_pkg::CHK_W-1:0] s2_checks_ok_i,
  input wire logic s1_position_i,
  input wire logic s2_position_i,
  input wire logic service_tool_i,
  input wire logic transfer_inhibit_i,
  input wire logic panel_reset_i,
  input wire logic transfer_done_i,
  input wire logic [tses_pkg::FLT_N-1:0] fault_i,
  // load sequencer, same clock
  input wire logic [7:0] seq_out_i,
  // panel leds and relays
  output logic s1_conn_led_o,
  output logic s1_conn_relay_o,
  output logic s1_avail_led_o,
  output logic s1_avail_relay_o,
  output logic s2_conn_led_o,
  output logic s2_conn_relay_o,
  output logic s2_avail_led_o,
  output logic s2_avail_relay_o,
  output logic test_led_o,
  output logic test_relay_o,
  // generator and network controls
  output logic emerg_start_a_o,
  output logic emerg_start_b_o,
  output logic pretransfer_o,
  output logic speed_raise_o,
  output logic sync_enable_o,
  output logic [7:0] seq_event_o,
  // display and status led
  output logic [15:0] disp_code_o,
  output logic [7:0] disp_secs_o,
  output logic status_led_o
);
  import tses_pkg::*;

  localparam int PRE_W = $clog2(QTR_CYCLES);

  // refuse settings the counters cannot serve
  if (QTR_CYCLES < 2 || HIST_DEPTH < 1 || HIST_DEPTH > 63) begin : g_chk
    $error("tses_core: bad QTR_CYCLES or HIST_DEPTH");
  end

  typedef struct packed {
    logic [PIN_W-1:0] sy1;
    logic [PIN_W-1:0] sy2;
    logic [PIN_W-1:0] sy3;
    logic [PIN_W-1:0] pin;
    logic btn;
    logic done;
    logic [7:0] seq_q;
    logic [7:0] seq_chg;
    logic [7:0] seq_ev;
    logic [CTRL_W-1:0] ctrl;
    logic speed;
    logic [TMR_N-1:0][7:0] tmr;
    logic [PRE_W-1:0] pre;
    logic [1:0] qtr;
    logic hb;
    logic start_a;
    logic [FLT_N-1:0] latched;
    logic [FLT_N:0] to_hist;
    logic [HIST_DEPTH-1:0][15:0] hist;
    logic [5:0] hwr;
    logic [5:0] hcnt;
    logic [5:0] hidx;
    tses_flash_type fst;
    logic fsel;
    logic [1:0] dig;
    logic [3:0] cnt;
    logic [3:0] wt;
    logic led;
    logic [EV_W-1:0] ev;
    logic emerg_a;
    logic emerg_b;
    logic [15:0] dcode;
    logic [7:0] dsecs;
    logic ack;
    logic [31:0] dat;
  } tses_state_type;

  tses_state_type r;
  tses_state_type n;
  logic [PIN_W-1:0] pins;
  logic qtick;
  logic stick;
  logic qexp;
  logic btn_rise;
  logic done_rise;
  logic req;
  logic wr;
  logic [TMR_N-1:0] texp;
  logic [FLASH_N-1:0] fl;
  logic [15:0] fcode;
  logic [15:0] ncode;
  logic [FLT_N:0] pop;
  logic [15:0] hcode;
  logic [FLT_N:0] push_new;

  // pin gathering; all pass the three-stage synchroniser
  assign pins = {fault_i, transfer_done_i, panel_reset_i,
    transfer_inhibit_i, service_tool_i, s2_position_i, s1_position_i,
    s2_checks_ok_i, s1_checks_ok_i};

  always_comb begin
    n = r;
    // sync chain; a bit changes once stages two and three agree
    n.sy1 = pins;
    n.sy2 = r.sy1;
    n.sy3 = r.sy2;
    n.pin = (r.sy2 & r.sy3) | (r.pin & (r.sy2 ^ r.sy3));
    n.btn = r.pin[P_RST];
    n.done = r.pin[P_DONE];
    btn_rise = r.pin[P_RST] & ~r.btn;
    done_rise = r.pin[P_DONE] & ~r.done;

    // quarter-second and second ticks from one prescaler
    qtick = r.pre == PRE_W'(QTR_CYCLES - 1);
    n.pre = qtick ? '0 : r.pre + 1'b1;
    stick = qtick && r.qtr == 2'(QTR_PER_SEC - 1);
    if (qtick) begin
      n.qtr = r.qtr + 1'b1;
    end
    if (stick) begin
      n.hb = ~r.hb;
    end

    // delay timers count whole seconds down to idle
    for (int i = 0; i < TMR_N; i++) begin
      texp[i] = stick && r.tmr[i] == 8'h01;
      if (stick && r.tmr[i] != 8'h00) begin
        n.tmr[i] = r.tmr[i] - 1'b1;
      end
    end
    // start A once its delay runs out, dropped after cool-down
    if (texp[T_START_A]) begin
      n.start_a = 1'b1;
    end else if (texp[T_COOL]) begin
      n.start_a = 1'b0;
    end

    // sequencer changes; mode gate stops them outside utility-to-genset
    n.seq_q = seq_out_i;
    n.seq_ev = (seq_out_i ^ r.seq_q) & {8{r.ctrl[C_UTG]}};
    n.seq_chg = r.seq_chg | n.seq_ev;

    // faults latch; a fault still present survives the reset press
    n.latched = (r.latched & ~{FLT_N{btn_rise}})
      | r.pin[P_FLT +: FLT_N];
    // only faults the press really clears move on to history
    push_new = {1'b0, r.latched & ~r.pin[P_FLT +: FLT_N]
      & {FLT_N{btn_rise}}};

    // speed request ends at transfer done
    if (done_rise) begin
      n.speed = 1'b0;
    end

    // wishbone: ack one cycle after the strobe, dropped the next
    req = wb_cyc_i && wb_stb_i && !r.ack;
    wr = req && wb_we_i;
    n.ack = req;
    n.dat = 32'h0000_0000;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        REG_CTRL: n.dat = {25'h0, r.speed, r.ctrl};
        REG_EVENTS: n.dat = {15'h0, r.ev};
        REG_SEQ: n.dat = {24'h0, r.seq_chg};
        REG_FAULT: n.dat = {28'h0, r.latched};
        REG_HIDX: n.dat = {16'h0, 2'h0, r.hcnt, 2'h0, r.hwr};
        REG_HDATA: begin
          if (r.hidx < 6'(HIST_DEPTH)) begin
            n.dat = {16'h0, r.hist[r.hidx]};
          end
        end
        default: n.dat = 32'h0000_0000;
      endcase
    end
    if (wr && wb_sel_i[0]) begin
      case (wb_adr_i)
        REG_CTRL: begin
          n.ctrl = wb_dat_i[CTRL_W-1:0];
          if (wb_dat_i[C_SPEED]) begin
            n.speed = 1'b1;
            push_new[FLT_N] = 1'b1;
          end
        end
        REG_TIMER: begin
          // both low lanes needed: slot and seconds arrive together
          if (wb_sel_i[1] && wb_dat_i[2:0] < 3'(TMR_N)) begin
            n.tmr[wb_dat_i[2:0]] = wb_dat_i[15:8];
          end
        end
        // write one to clear, a change in the same cycle still sets
        REG_SEQ: n.seq_chg = (r.seq_chg & ~wb_dat_i[7:0]) | n.seq_ev;
        REG_HIDX: n.hidx = wb_dat_i[5:0];
        default: ;
      endcase
    end

    // history: one queued code moves in per cycle, oldest overwritten
    pop = '0;
    for (int i = FLT_N; i >= 0; i--) begin
      if (r.to_hist[i]) begin
        pop = '0;
        pop[i] = 1'b1;
      end
    end
    hcode = pop[FLT_N] ? CODE_SPEED : 16'h0000;
    for (int i = 0; i < FLT_N; i++) begin
      if (pop[i]) begin
        hcode = FAULT_CODE[i];
      end
    end
    if (|pop) begin
      n.hist[r.hwr] = hcode;
      n.hwr = (r.hwr == 6'(HIST_DEPTH - 1)) ? 6'h00 : r.hwr + 1'b1;
      if (r.hcnt != 6'(HIST_DEPTH)) begin
        n.hcnt = r.hcnt + 1'b1;
      end
    end
    n.to_hist = (r.to_hist & ~pop) | push_new;

    // event vector, one cycle behind the synchronised pins
    n.ev[E_S1CON] = r.pin[P_S1POS];
    n.ev[E_S2CON] = r.pin[P_S2POS];
    n.ev[E_S1AV] = &r.pin[P_S1 +: CHK_W];
    n.ev[E_S2AV] = &r.pin[P_S2 +: CHK_W];
    n.ev[E_TEST] = r.ctrl[C_TEST];
    n.ev[E_TSA] = r.ctrl[C_TEST];
    n.ev[E_TSB] = r.ctrl[C_TEST] & r.ctrl[C_G2G]
      & r.ctrl[C_TEST_S2];
    for (int i = 0; i < TMR_N; i++) begin
      n.ev[E_TMR0 + i] = r.tmr[i] != 8'h00;
    end
    n.ev[E_SYNC] = r.ctrl[C_SYNC];
    n.ev[E_INH] = r.pin[P_INH];
    n.ev[E_SVC] = r.pin[P_SVC];
    n.ev[E_SPEED] = r.speed;
    n.emerg_a = r.ctrl[C_TEST] | r.start_a;
    n.emerg_b = r.ev[E_TSB];

    // display: lowest running delay wins, then sync, then position
    n.dcode = 16'h0000;
    n.dsecs = 8'h00;
    if (r.ev[E_S2CON]) begin
      n.dcode = CODE_S2CON;
    end
    if (r.ev[E_S1CON]) begin
      n.dcode = CODE_S1CON;
    end
    if (r.ev[E_SYNC] && r.ctrl[C_ASYNC]) begin
      n.dcode = CODE_SYNC;
    end
    for (int i = TMR_N - 1; i >= 0; i--) begin
      if (r.tmr[i] != 8'h00) begin
        n.dcode = TMR_CODE[i];
        n.dsecs = r.tmr[i];
      end
    end

    // flash-out of latched flagged faults
    for (int k = 0; k < FLASH_N; k++) begin
      fl[k] = r.latched[FLASH_BIT[k]];
    end
    fcode = FAULT_CODE[FLASH_BIT[r.fsel]];
    ncode = FAULT_CODE[FLASH_BIT[!fl[0]]];
    qexp = qtick && r.wt == 4'h0;
    if (qtick && r.wt != 4'h0) begin
      n.wt = r.wt - 1'b1;
    end
    case (r.fst)
      F_IDLE: begin
        n.led = r.hb;
        if (|fl) begin
          n.fsel = !fl[0];
          n.dig = FLASH_TOP[!fl[0]];
          n.cnt = ncode[{FLASH_TOP[!fl[0]], 2'b00} +: 4];
          n.wt = PULSE_Q;
          n.led = 1'b1;
          n.fst = F_ON;
        end
      end
      F_ON: begin
        if (qexp) begin
          n.led = 1'b0;
          n.wt = PULSE_Q;
          n.fst = F_OFF;
        end
      end
      F_OFF: begin
        if (qexp) begin
          if (r.cnt > 4'h1) begin
            n.cnt = r.cnt - 1'b1;
            n.led = 1'b1;
            n.wt = PULSE_Q;
            n.fst = F_ON;
          end else if (r.dig != 2'h0) begin
            n.dig = r.dig - 1'b1;
            n.cnt = fcode[{r.dig - 1'b1, 2'b00} +: 4];
            n.wt = DGAP_Q;
            n.fst = F_PAUSE;
          end else begin
            n.wt = RGAP_Q;
            n.fst = F_REST;
          end
        end
      end
      F_PAUSE: begin
        if (qexp) begin
          n.led = 1'b1;
          n.wt = PULSE_Q;
          n.fst = F_ON;
        end
      end
      F_REST: begin
        if (qexp) begin
          n.fst = F_IDLE;
        end
      end
      default: n.fst = F_IDLE;
    endcase
    // acknowledged code stops at once, next one picked from idle
    if (r.fst != F_IDLE && !fl[r.fsel]) begin
      n.fst = F_IDLE;
      n.led = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.ctrl <= CTRL_RST;
      r.fst <= F_IDLE;
    end else begin
      r <= n;
    end
  end

  // outputs straight from state
  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign s1_conn_led_o = r.ev[E_S1CON];
  assign s1_conn_relay_o = r.ev[E_S1CON];
  assign s1_avail_led_o = r.ev[E_S1AV];
  assign s1_avail_relay_o = r.ev[E_S1AV];
  assign s2_conn_led_o = r.ev[E_S2CON];
  assign s2_conn_relay_o = r.ev[E_S2CON];
  assign s2_avail_led_o = r.ev[E_S2AV];
  assign s2_avail_relay_o = r.ev[E_S2AV];
  assign test_led_o = r.ev[E_TEST];
  assign test_relay_o = r.ev[E_TEST];
  assign emerg_start_a_o = r.emerg_a;
  assign emerg_start_b_o = r.emerg_b;
  assign pretransfer_o = r.ev[E_TRANSFER_PENDING_DELAY];
  assign speed_raise_o = r.ev[E_SPEED];
  assign sync_enable_o = r.ev[E_SYNC];
  assign seq_event_o = r.seq_ev;
  assign disp_code_o = r.dcode;
  assign disp_secs_o = r.dsecs;
  assign status_led_o = r.led;
endmodule // tses_core

// *** testbench/tses_core_asserts.sv ***
// checker for the event/status block, bound to tses_core
// assumes one clock domain and synchronous active-high reset
`timescale 1ns/1ns
module tses_core_asserts #(
  parameter int QTR_CYCLES = 8
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins
  input wire logic [tses_pkg::CHK_W-1:0] s1_checks_ok_i,
  input wire logic [tses_pkg::CHK_W-1:0] s2_checks_ok_i,
  input wire logic s1_position_i,
  input wire logic s2_position_i,
  input wire logic transfer_done_i,
  input wire logic panel_reset_i,
  input wire logic [7:0] seq_out_i,
  // outputs watched
  input wire logic s1_conn_led_o,
  input wire logic s1_conn_relay_o,
  input wire logic s1_avail_led_o,
  input wire logic s1_avail_relay_o,
  input wire logic s2_avail_led_o,
  input wire logic s2_conn_led_o,
  input wire logic test_led_o,
  input wire logic test_relay_o,
  input wire logic emerg_start_a_o,
  input wire logic speed_raise_o,
  input wire logic [7:0] seq_event_o,
  input wire logic status_led_o
);
  import tses_pkg::*;
  int unsigned hi_cnt;
  int unsigned calm_cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // request taken, then its single answer
  sequence bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence led_fall;
    $fell(status_led_o);
  endsequence
  // length of the current high phase of the status led
  always_ff @(posedge clk_i) begin
    hi_cnt <= status_led_o ? hi_cnt + 1 : 0;
  end
  // cycles since the panel button was last seen pressed; an acknowledge
  // cuts a flash pulse and leaves a partial heartbeat phase behind it
  always_ff @(posedge clk_i) begin
    if (panel_reset_i) calm_cnt <= 0;
    else if (calm_cnt < 1000) calm_cnt <= calm_cnt + 1;
  end
  chk_ack_next: assert property (bus_req |=> wb_ack_o)
    else $error("ack late");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_s1_avail: assert property (
    (&s1_checks_ok_i)[*6] |-> s1_avail_led_o && s1_avail_relay_o)
    else $error("source one available missing");
  chk_s2_lost: assert property (
    (!(&s2_checks_ok_i))[*6] |-> !s2_avail_led_o)
    else $error("source two available while out of limits");
  chk_conn_pins: assert property (
    (s1_position_i && !s2_position_i)[*6] |->
      s1_conn_led_o && s1_conn_relay_o && !s2_conn_led_o)
    else $error("connected outputs not following position");
  chk_test_outs: assert property (
    test_led_o |-> test_relay_o && emerg_start_a_o)
    else $error("test outputs inconsistent");
  chk_seq_quiet: assert property (
    $stable(seq_out_i)[*3] |-> seq_event_o == 8'h00)
    else $error("sequencer event without change");
  chk_speed_end: assert property (
    (transfer_done_i && !(wb_cyc_i && wb_we_i))[*8] |-> !speed_raise_o)
    else $error("speed request outlives transfer");
  chk_led_pulse: assert property (
    led_fall ##0 (calm_cnt > 5 * QTR_CYCLES) |-> hi_cnt >= QTR_CYCLES)
    else $error("status led pulse too short");
endmodule // tses_core_asserts

bind tses_core tses_core_asserts #(.QTR_CYCLES(QTR_CYCLES)) u_chk (.*);

// *** testbench/tses_panel_model.sv ***
// far-side model: sources, switch position, panel button, generator
// assumes callers invoke its tasks just after a rising clock edge
`timescale 1ns/1ns
module tses_panel_model (
  // clock
  input wire logic clk_i,
  // source sensing and switch position
  output logic [tses_pkg::CHK_W-1:0] s1_ok_o,
  output logic [tses_pkg::CHK_W-1:0] s2_ok_o,
  output logic s1_pos_o,
  output logic s2_pos_o,
  // tool, inhibit, panel and generator side
  output logic svc_o,
  output logic inh_o,
  output logic prst_o,
  output logic done_o,
  output logic [tses_pkg::FLT_N-1:0] flt_o
);
  import tses_pkg::*;
  // all pins released at power-up
  initial begin
    {s1_ok_o, s2_ok_o, s1_pos_o, s2_pos_o} = '0;
    {svc_o, inh_o, prst_o, done_o, flt_o} = '0;
  end
  // pins are levels; the block resynchronises them itself
  task automatic pins(input logic [4:0] a, b, input logic p1, p2, sv,
      ih, dn, input logic [3:0] f);
    s1_ok_o <= a;
    s2_ok_o <= b;
    s1_pos_o <= p1;
    s2_pos_o <= p2;
    svc_o <= sv;
    inh_o <= ih;
    done_o <= dn;
    flt_o <= f;
  endtask
  // button held long enough to pass the synchroniser
  task automatic press();
    prst_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    prst_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
endmodule // tses_panel_model

// *** testbench/tb_top.sv ***
// self-checking bench for tses_core with the far-side model
// assumes a quarter second shortened to 8 cycles, so 1 s is 32
`timescale 1ns/1ns
module tb_top;
  import tses_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, seq_out_i, seq_event_o, disp_secs_o;
  logic [3:0] wb_sel_i, fault_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, h;
  logic [4:0] s1_checks_ok_i, s2_checks_ok_i;
  logic s1_position_i, s2_position_i, service_tool_i;
  logic transfer_inhibit_i, panel_reset_i, transfer_done_i;
  logic s1_conn_led_o, s1_conn_relay_o, s1_avail_led_o, s1_avail_relay_o;
  logic s2_conn_led_o, s2_conn_relay_o, s2_avail_led_o, s2_avail_relay_o;
  logic test_led_o, test_relay_o, emerg_start_a_o, emerg_start_b_o;
  logic pretransfer_o, speed_raise_o, sync_enable_o, status_led_o, l;
  logic [15:0] disp_code_o;
  int n_errors, tests_run, n;
  tses_core #(.QTR_CYCLES(8), .HIST_DEPTH(50)) dut (.*);
  tses_panel_model pm (.clk_i(clk_i), .s1_ok_o(s1_checks_ok_i),
    .s2_ok_o(s2_checks_ok_i), .s1_pos_o(s1_position_i),
    .s2_pos_o(s2_position_i), .svc_o(service_tool_i),
    .inh_o(transfer_inhibit_i), .prst_o(panel_reset_i),
    .done_o(transfer_done_i), .flt_o(fault_i));
  // 50 ns clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, got);
    end
  endtask
  // classic single cycle: held until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // led rises up to the first low stretch of ten quarters (repeat gap)
  task automatic flash_count(output int c);
    int lo;
    c = 0;
    lo = 0;
    while (lo < 80) begin
      @(posedge clk_i);
      if (status_led_o) begin
        if (lo > 0) c++;
        lo = 0;
      end else lo++;
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // whole run is about 2500 cycles; allow twelve times that
  initial begin
    #1500000;
    n_errors++;
    wrap_up;
  end
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hF;
    seq_out_i = 8'h00;
    rst_i = 1'b1;
    wt(3);
    rst_i <= 1'b0;
    rd(REG_CTRL, q);
    chk("ctrl reset", q, 32'h0);
    wr(8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC, q);
    chk("unmapped", q, 32'h0);
    $display("test bus done");
    // sources: source one full, source two one check short, then each source one check failing alone
    pm.pins(5'h1F, 5'h1E, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    wt(8);
    rd(REG_EVENTS, q);
    chk("src events", q[3:0], 4'h3);
    chk("src outs", {s1_avail_led_o, s1_avail_relay_o, s1_conn_led_o,
      s1_conn_relay_o, s2_avail_led_o, s2_avail_relay_o, s2_conn_led_o,
      s2_conn_relay_o}, 8'hF0);
    chk("disp s1", disp_code_o, CODE_S1CON);
    for (int i = 0; i < 5; i++) begin
      pm.pins(~(5'h01 << i), 5'h1F, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
      wt(8);
      rd(REG_EVENTS, q);
      chk("src fail", q[3:0], 4'hC);
      chk("disp s2", disp_code_o, CODE_S2CON);
      chk("s2 outs", {s2_avail_led_o, s2_avail_relay_o, s2_conn_led_o,
        s2_conn_relay_o}, 4'hF);
    end
    $display("test sources done");
    // sequencer: ignored outside utility-to-genset mode
    for (int m = 0; m < 2; m++) begin
      wr(REG_CTRL, m);
      seq_out_i <= seq_out_i ^ (m ? 8'h08 : 8'hFF);
      q = 0;
      repeat (4) begin
        @(posedge clk_i);
        q[7:0] = q[7:0] | seq_event_o;
      end
      chk("seq pulse", q, m ? 32'h08 : 32'h0);
      rd(REG_SEQ, q);
      chk("seq sticky", q, m ? 32'h08 : 32'h0);
    end
    wr(REG_SEQ, 32'hFF);
    rd(REG_SEQ, q);
    chk("seq clear", q, 32'h0);
    $display("test sequencer done");
    // each delay timer for 2 s, in slot order
    for (int s = 0; s < TMR_N; s++) begin
      wr(REG_TIMER, {16'h0, 8'h02, 5'h0, 3'(s)});
      rd(REG_EVENTS, q);
      chk("tmr on", q[E_TMR0+s], 1'b1);
      chk("tmr code", disp_code_o, TMR_CODE[s]);
      chk("tmr secs", disp_secs_o inside {8'h01, 8'h02}, 1'b1);
      chk("pretransfer", pretransfer_o, s == 5);
      chk("start a", emerg_start_a_o, s inside {1, 2, 3});
      n = 0;
      do begin
        rd(REG_EVENTS, q);
        n++;
      end while (q[E_TMR0+s] && n < 100);
      chk("tmr span", n > 10 && n < 23, 1'b1);
    end
    $display("test timers done");
    // test runs, with and without genset-to-genset
    wr(REG_CTRL, 32'h1B);
    rd(REG_EVENTS, q);
    chk("test ev", {q[12], q[5:4]}, 3'h7);
    chk("test outs", {test_led_o, test_relay_o, emerg_start_a_o,
      emerg_start_b_o}, 4'hF);
    wr(REG_CTRL, 32'h19);
    rd(REG_EVENTS, q);
    chk("no g2g", {q[5:4], emerg_start_b_o}, 3'h2);
    $display("test exercise done");
    // sync, inhibit, service tool, speed request
    pm.pins(5'h1F, 5'h1F, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'h0);
    wr(REG_CTRL, 32'h24);
    wt(8);
    rd(REG_EVENTS, q);
    chk("misc ev", q[15:13], 3'h7);
    chk("sync out", {sync_enable_o, disp_code_o}, {1'b1, CODE_SYNC});
    wr(REG_CTRL, 32'h20);
    chk("sync hidden", disp_code_o, CODE_S1CON);
    rd(REG_HIDX, h);
    wr(REG_CTRL, 32'h40);
    rd(REG_HIDX, q);
    chk("speed on", speed_raise_o, 1'b1);
    chk("speed log", q[13:8], h[13:8] + 6'h01);
    wr(REG_HIDX, {26'h0, h[5:0]});
    rd(REG_HDATA, q);
    chk("hist code", q, {16'h0, CODE_SPEED});
    pm.pins(5'h1F, 5'h1F, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0);
    wt(8);
    chk("speed end", speed_raise_o, 1'b0);
    $display("test messaging done");
    // faults latch; reset clears only those whose pin is low
    pm.pins(5'h1F, 5'h1F, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h7);
    wt(8);
    pm.pins(5'h1F, 5'h1F, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h4);
    wt(8);
    rd(REG_FAULT, q);
    chk("latched", q, 32'h7);
    rd(REG_HIDX, h);
    pm.press();
    rd(REG_FAULT, q);
    chk("ack keeps", q, 32'h4);
    rd(REG_HIDX, q);
    chk("history", q[13:8], h[13:8] + 6'h02);
    pm.pins(5'h1F, 5'h1F, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    pm.press();
    rd(REG_FAULT, q);
    chk("all clear", q, 32'h0);
    // flash-out: 441 ahead of 1121, 1121 once 441 is acknowledged
    pm.pins(5'h1F, 5'h1F, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h9);
    flash_count(n);
    flash_count(n);
    chk("flash first", n, 32'd9);
    pm.pins(5'h1F, 5'h1F, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h8);
    pm.press();
    flash_count(n);
    flash_count(n);
    chk("flash next", n, 32'd5);
    pm.pins(5'h1F, 5'h1F, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    pm.press();
    // heartbeat: skip two edges, then time one phase
    repeat (3) begin
      l = status_led_o;
      n = 0;
      while (status_led_o === l) begin
        @(posedge clk_i);
        n++;
      end
    end
    chk("heartbeat", n, 32'd32);
    $display("test faults done");
    wrap_up;
  end
endmodule // tb_top
